// >>> cisl_can_model.sv
// Stands in for the CAN engine: pulses last one clock, counts are levels
module cisl_can_model (
  input wire logic clk_i,
  output cisl_pkg::cisl_can_evt_t evt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  cisl_pkg::cisl_can_evt_t lvl;
  initial
  begin
    lvl = '0;
    evt_o = '0;
  end
  task automatic fire(input cisl_pkg::cisl_can_evt_t p);
    evt_o <= lvl | p;
    @(posedge clk_i);
    evt_o <= lvl;
  endtask : fire
  task automatic hold(input cisl_pkg::cisl_can_evt_t l);
    lvl = l;
    evt_o <= l;
  endtask : hold
endmodule : cisl_can_model

// >>> cisl_flag.sv
// Sticky flag; a set in the same cycle as a clear wins
module cisl_flag (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic set_i,
  input wire logic clr_i,
  input wire logic hold_i,
  output logic flag_o
);
  logic nxt_flag;

  always_comb
  begin
    nxt_flag = flag_o;
    // Clear is refused while the cause still stands
    if (clr_i && !hold_i)
    begin
      nxt_flag = 1'b0;
    end
    if (set_i)
    begin
      nxt_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag_o <= 1'b0;
    end
    else if (ce_i)
    begin
      flag_o <= nxt_flag;
    end
  end
endmodule : cisl_flag

// >>> cisl_monitor.sv
module cisl_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire cisl_pkg::cisl_can_evt_t evt_i,
  input wire logic sleep_i,
  input wire logic wake_o,
  input wire logic [2:0] err_state_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_single_pulse: assert property (s_req |=> s_ack)
    else $error("ack missing or held too long");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_busoff_entry: assert property (
    ce_i && evt_i.tx_errcnt[8] |=> err_state_o == 3'b100)
    else $error("bus-off state not entered");
  a_passive_entry: assert property (
    ce_i && !evt_i.tx_errcnt[8] && (evt_i.rx_errcnt > 8'h7F ||
    evt_i.tx_errcnt > 9'h07F) |=> err_state_o == 3'b010)
    else $error("error-passive state not entered");
  a_active_stay: assert property (
    ce_i && evt_i.rx_errcnt < 8'h80 && evt_i.tx_errcnt < 9'h080
    |=> err_state_o == 3'b001)
    else $error("error-active state lost");
  a_state_one_hot: assert property ($onehot(err_state_o))
    else $error("error state not one-hot");
  a_wake_has_cause: assert property (
    wake_o |-> $past(sleep_i && evt_i.bus_activity))
    else $error("wake without bus activity in sleep");
  a_wake_one_pulse: assert property (wake_o |=> !wake_o)
    else $error("wake longer than one cycle");
endmodule : cisl_monitor

bind cisl_top cisl_monitor i_cisl_monitor (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .evt_i(evt_i), .sleep_i(sleep_i),
  .wake_o(wake_o), .err_state_o(err_state_o));

// >>> cisl_pkg.sv
package cisl_pkg;
  localparam int NTX = 3;
  localparam int NRX = 2;
  localparam int FIFO_IDX_W = 3;
  localparam logic [7:0] WARN_LIMIT = 8'h60;
  localparam logic [7:0] PASSIVE_LIMIT = 8'h7F;
  localparam logic [3:0] FIFO_WM_FULL = 4'h8;
  localparam logic [3:0] FIFO_WM_LOW = 4'h4;

  // Word addresses (byte address = index * 4)
  localparam logic [3:0] ADR_MODE = 4'h0;
  localparam logic [3:0] ADR_FLAG = 4'h1;
  localparam logic [3:0] ADR_ENABLE = 4'h2;
  localparam logic [3:0] ADR_BUFEN = 4'h3;
  localparam logic [3:0] ADR_COMM = 4'h4;
  localparam logic [3:0] ADR_MASKSEL = 4'h5;
  localparam logic [3:0] ADR_BUFSTAT = 4'h6;

  // Flag register bit positions
  localparam int FB_TX0 = 0;
  localparam int FB_SHTX = 3;
  localparam int FB_RX0 = 4;
  localparam int FB_SHRX = 6;
  localparam int FB_WM = 7;
  localparam int FB_MERR = 8;
  localparam int FB_WAKE = 9;
  localparam int FB_ERR = 10;
  localparam int FLAG_W = 11;

  // Comm status bit positions
  localparam int CB_OVF0 = 0;
  localparam int CB_RXWARN = 2;
  localparam int CB_TXWARN = 3;
  localparam int CB_RXPASS = 4;
  localparam int CB_TXPASS = 5;
  localparam int CB_BUSOFF = 6;
  localparam int COMM_W = 7;

  localparam logic [1:0] MODE_LEGACY = 2'h0;
  localparam logic [1:0] MODE_ENH = 2'h1;
  localparam logic [1:0] MODE_FIFO = 2'h2;
  localparam logic [7:0] MASKSEL_RST = 8'h00;

  // Field positions inside the mode, buffer enable and status words
  localparam int MB_WMSEL = 2;
  localparam int BE_RX0 = 4;
  localparam int BS_PTR0 = 8;
  localparam int BS_STATE0 = 16;

  typedef struct packed {
    logic [NTX-1:0] tx_empty;
    logic [NTX-1:0] tx_done;
    logic [NTX-1:0] tx_req;
    logic [NRX-1:0] rx_loaded;
    logic [NRX-1:0] rx_full;
    logic [NRX-1:0] rx_nobuf;
    logic [3:0] fifo_count;
    logic [FIFO_IDX_W-1:0] fifo_ptr;
    logic msg_error;
    logic bus_activity;
    logic [7:0] rx_errcnt;
    logic [8:0] tx_errcnt;
  } cisl_can_evt_t;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b001,
    ST_PASSIVE = 3'b010,
    ST_BUSOFF = 3'b100
  } cisl_err_state_t;
endpackage : cisl_pkg

// >>> cisl_top.sv
// Function
// - Legacy mode: each transmit buffer has own flag, set on empty.
// - Enhanced modes: one shared transmit flag, set on buffer completion.
// - Enhanced transmit interrupt gated by shared and per-buffer enables.
// - Receive interrupt raised when a received message is loaded.
// - Legacy mode: each receive buffer has own flag, cleared by write.
// - Enhanced modes: one shared receive flag gated by per-buffer enables.
// - FIFO mode: receive flag on FIFO load; read pointer readable.
// - FIFO mode: watermark flag at full (8) or low (4) level chosen by config bit.
// - Any message error sets message error flag; interrupt if enabled.
// - Bus activity in sleep sets wake flag, interrupts, ends sleep.
// - Error interrupt on overflow or any error state change.
// - Overflow bit sets when tied receive buffer cannot accept message.
// - Receiver warning when receive error count reaches 96.
// - Transmitter warning when transmit error count reaches 96.
// - Receive count above 127 gives error-passive and receiver flag.
// - Transmit count above 127 gives error-passive and transmitter flag.
// - Transmit count above 255 gives bus-off and bus-off flag.
// - Flags stay pending and resist clear while the condition remains.
module cisl_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire cisl_pkg::cisl_can_evt_t evt_i,
  input wire logic sleep_i,
  output logic irq_o,
  output logic wake_o,
  output logic [7:0] filter_mask_select_b_o,
  output logic [2:0] err_state_o
);
  logic [1:0] mode_ff;
  logic fifo_watermark_level_ff;
  logic [cisl_pkg::FLAG_W-1:0] enable_ff;
  logic [cisl_pkg::NTX-1:0] tx_buf_en_ff;
  logic [cisl_pkg::NRX-1:0] rx_buf_en_ff;
  logic [7:0] filter_mask_select_b_ff;
  logic [cisl_pkg::FLAG_W-1:0] flags;
  logic [cisl_pkg::COMM_W-1:0] comm;
  logic [cisl_pkg::FLAG_W-1:0] flag_set;
  logic [cisl_pkg::FLAG_W-1:0] flag_hold;
  logic [cisl_pkg::COMM_W-1:0] comm_set;
  logic [cisl_pkg::COMM_W-1:0] comm_hold;
  cisl_pkg::cisl_err_state_t st_ff;
  cisl_pkg::cisl_err_state_t nxt_st;
  logic [1:0] prev_warn_ff;
  logic [3:0] wm_level;
  logic legacy;
  logic enh;
  logic fifo_mode;
  logic enh_any;
  logic wb_req;
  logic wb_wr;
  logic wr_flag;
  logic wr_comm;
  logic rx_warn;
  logic tx_warn;
  logic rx_pass;
  logic tx_pass;
  logic bus_off;
  logic err_change;

  assign legacy = (mode_ff == cisl_pkg::MODE_LEGACY);
  assign enh = (mode_ff == cisl_pkg::MODE_ENH);
  assign fifo_mode = (mode_ff == cisl_pkg::MODE_FIFO);
  // Reserved mode code 3 acts as no mode: only message error, wake, error and comm bits set, mask select hidden
  assign enh_any = enh || fifo_mode;
  // Registered ack masks the held strobe: one take per request
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  assign wr_flag = wb_wr
    && (wb_adr_i[5:2] == cisl_pkg::ADR_FLAG);
  assign wr_comm = wb_wr
    && (wb_adr_i[5:2] == cisl_pkg::ADR_COMM);

  // Error thresholds; tx count is 9 bits so it can pass 255
  assign rx_warn = (evt_i.rx_errcnt >= cisl_pkg::WARN_LIMIT);
  assign tx_warn = (evt_i.tx_errcnt >= {1'b0, cisl_pkg::WARN_LIMIT});
  assign rx_pass = (evt_i.rx_errcnt > cisl_pkg::PASSIVE_LIMIT);
  assign tx_pass = (evt_i.tx_errcnt > {1'b0, cisl_pkg::PASSIVE_LIMIT});
  assign bus_off = evt_i.tx_errcnt[8];

  always_comb
  begin
    nxt_st = cisl_pkg::ST_ACTIVE;
    if (bus_off)
    begin
      nxt_st = cisl_pkg::ST_BUSOFF;
    end
    else if (rx_pass || tx_pass)
    begin
      nxt_st = cisl_pkg::ST_PASSIVE;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= cisl_pkg::ST_ACTIVE;
      prev_warn_ff <= '0;
    end
    else if (ce_i)
    begin
      st_ff <= nxt_st;
      prev_warn_ff <= {rx_warn, tx_warn};
    end
  end

  // Warning transitions count as error state changes too
  assign err_change = (nxt_st != st_ff)
    || (prev_warn_ff[1] != rx_warn) || (prev_warn_ff[0] != tx_warn);

  assign wm_level = fifo_watermark_level_ff ? cisl_pkg::FIFO_WM_LOW
    : cisl_pkg::FIFO_WM_FULL;

  always_comb
  begin
    flag_set = '0;
    flag_hold = '0;
    if (legacy)
    begin
      flag_set[cisl_pkg::FB_TX0 +: cisl_pkg::NTX] = evt_i.tx_empty;
      flag_set[cisl_pkg::FB_RX0 +: cisl_pkg::NRX] = evt_i.rx_loaded;
    end
    else if (enh_any)
    begin
      flag_set[cisl_pkg::FB_SHTX] = |(evt_i.tx_done & tx_buf_en_ff);
      flag_set[cisl_pkg::FB_SHRX] = |(evt_i.rx_loaded & rx_buf_en_ff);
    end
    if (fifo_mode)
    begin
      flag_set[cisl_pkg::FB_WM] = (evt_i.fifo_count >= wm_level);
      // Watermark is a level: its clear is refused while the FIFO sits at or above the level
      flag_hold[cisl_pkg::FB_WM] = flag_set[cisl_pkg::FB_WM];
    end
    flag_set[cisl_pkg::FB_MERR] = evt_i.msg_error;
    flag_set[cisl_pkg::FB_WAKE] = sleep_i && evt_i.bus_activity
      && enable_ff[cisl_pkg::FB_WAKE];
    flag_set[cisl_pkg::FB_ERR] = err_change || |evt_i.rx_nobuf;
  end

  always_comb
  begin
    comm_set = '0;
    comm_hold = '0;
    comm_set[cisl_pkg::CB_OVF0 +: cisl_pkg::NRX] = evt_i.rx_nobuf;
    comm_set[cisl_pkg::CB_RXWARN] = rx_warn;
    comm_set[cisl_pkg::CB_TXWARN] = tx_warn;
    comm_set[cisl_pkg::CB_RXPASS] = rx_pass;
    comm_set[cisl_pkg::CB_TXPASS] = tx_pass;
    comm_set[cisl_pkg::CB_BUSOFF] = bus_off;
    comm_hold[cisl_pkg::COMM_W-1:cisl_pkg::CB_RXWARN] =
      comm_set[cisl_pkg::COMM_W-1:cisl_pkg::CB_RXWARN];
  end

  // One sticky cell per status bit; a same-cycle set beats the clear
  genvar gi;
  generate
    for (gi = 0; gi < cisl_pkg::FLAG_W; gi++)
    begin : g_flag
      cisl_flag u_flag (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .set_i(flag_set[gi]),
        .clr_i(wr_flag && !wb_dat_i[gi]),
        .hold_i(flag_hold[gi]),
        .flag_o(flags[gi])
      );
    end
    for (gi = 0; gi < cisl_pkg::COMM_W; gi++)
    begin : g_comm
      cisl_flag u_comm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .set_i(comm_set[gi]),
        .clr_i(wr_comm && !wb_dat_i[gi]),
        .hold_i(comm_hold[gi]),
        .flag_o(comm[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_ff <= cisl_pkg::MODE_LEGACY;
      fifo_watermark_level_ff <= 1'b0;
      enable_ff <= '0;
      tx_buf_en_ff <= '0;
      rx_buf_en_ff <= '0;
      filter_mask_select_b_ff <= cisl_pkg::MASKSEL_RST;
    end
    else if (ce_i && wb_wr)
    begin
      if (wb_adr_i[5:2] == cisl_pkg::ADR_MODE)
      begin
        mode_ff <= wb_dat_i[1:0];
        fifo_watermark_level_ff <= wb_dat_i[cisl_pkg::MB_WMSEL];
      end
      else if (wb_adr_i[5:2] == cisl_pkg::ADR_ENABLE)
      begin
        enable_ff[7:0] <= wb_dat_i[7:0];
      end
      else if (wb_adr_i[5:2] == cisl_pkg::ADR_BUFEN)
      begin
        tx_buf_en_ff <= wb_dat_i[cisl_pkg::NTX-1:0];
        rx_buf_en_ff <= wb_dat_i[cisl_pkg::BE_RX0 +: cisl_pkg::NRX];
      end
      else if (wb_adr_i[5:2] == cisl_pkg::ADR_MASKSEL && enh_any)
      begin
        // Dropped outside the enhanced modes, not parked for later
        filter_mask_select_b_ff <= wb_dat_i[7:0];
      end
    end
    if (!rst_i && ce_i && wb_req && wb_we_i && wb_sel_i[1]
      && wb_adr_i[5:2] == cisl_pkg::ADR_ENABLE)
    begin
      enable_ff[cisl_pkg::FLAG_W-1:8] <= wb_dat_i[cisl_pkg::FLAG_W-1:8];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_req;
      // Data follows the address each cycle, so it is valid with the ack
      wb_dat_o <= '0;
      if (wb_adr_i[5:2] == cisl_pkg::ADR_MODE)
      begin
        wb_dat_o[cisl_pkg::MB_WMSEL:0] <= {fifo_watermark_level_ff, mode_ff};
      end
      else if (wb_adr_i[5:2] == cisl_pkg::ADR_FLAG)
      begin
        wb_dat_o[cisl_pkg::FLAG_W-1:0] <= flags;
      end
      else if (wb_adr_i[5:2] == cisl_pkg::ADR_ENABLE)
      begin
        wb_dat_o[cisl_pkg::FLAG_W-1:0] <= enable_ff;
      end
      else if (wb_adr_i[5:2] == cisl_pkg::ADR_BUFEN)
      begin
        wb_dat_o[cisl_pkg::NTX-1:0] <= tx_buf_en_ff;
        wb_dat_o[cisl_pkg::BE_RX0 +: cisl_pkg::NRX] <= rx_buf_en_ff;
      end
      else if (wb_adr_i[5:2] == cisl_pkg::ADR_COMM)
      begin
        wb_dat_o[cisl_pkg::COMM_W-1:0] <= comm;
      end
      else if (wb_adr_i[5:2] == cisl_pkg::ADR_MASKSEL)
      begin
        wb_dat_o[7:0] <= enh_any ? filter_mask_select_b_ff
          : cisl_pkg::MASKSEL_RST;
      end
      else if (wb_adr_i[5:2] == cisl_pkg::ADR_BUFSTAT)
      begin
        wb_dat_o[cisl_pkg::NTX-1:0] <= evt_i.tx_req;
        wb_dat_o[cisl_pkg::BE_RX0 +: cisl_pkg::NRX] <= evt_i.rx_full;
        wb_dat_o[cisl_pkg::BS_PTR0 +: cisl_pkg::FIFO_IDX_W] <=
          evt_i.fifo_ptr;
        wb_dat_o[cisl_pkg::BS_STATE0 +: $bits(st_ff)] <= st_ff;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
      wake_o <= 1'b0;
      filter_mask_select_b_o <= cisl_pkg::MASKSEL_RST;
      err_state_o <= cisl_pkg::ST_ACTIVE;
    end
    else if (ce_i)
    begin
      // Registered, so the line trails the flags by one cycle
      irq_o <= |(flags & enable_ff);
      wake_o <= flag_set[cisl_pkg::FB_WAKE];
      filter_mask_select_b_o <= enh_any ? filter_mask_select_b_ff
        : cisl_pkg::MASKSEL_RST;
      err_state_o <= nxt_st;
    end
  end
endmodule : cisl_top

// >>> tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic sleep_i = 1'b0;
  logic ce = 1'b1;
  logic [2:0] est;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic irq;
  logic wake;
  logic [7:0] msel;
  cisl_pkg::cisl_can_evt_t evt;
  cisl_pkg::cisl_can_evt_t e;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  always #2.5 clk_i = ~clk_i;
  cisl_can_model i_cisl_can_model (.clk_i(clk_i), .evt_o(evt));
  cisl_top i_cisl_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .evt_i(evt), .sleep_i(sleep_i), .irq_o(irq), .wake_o(wake),
    .filter_mask_select_b_o(msel), .err_state_o(est));
  task automatic complete_run();
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // No fixed latency assumed; the watchdog ends a hung wait
  task automatic wb(input logic w, input logic [3:0] i, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd(input logic [3:0] i, input logic [31:0] exp);
    wb(1'b0, i, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic t_regs();
    rd(4'h5, 32'h0);
    rd(4'h6, 32'h0001_0000);
    wb(1'b1, 4'hF, 32'hFFFF_FFFF);
    rd(4'hF, 32'h0);
    wb(1'b1, 4'h5, 32'hE4);
    rd(4'h5, 32'h0);
    wb(1'b1, 4'h0, 32'h1);
    wb(1'b1, 4'h5, 32'hE4);
    rd(4'h5, 32'hE4);
    chk(msel, 32'hE4);
  endtask : t_regs
  task automatic t_legacy();
    wb(1'b1, 4'h0, 32'h0);
    wb(1'b1, 4'h2, 32'h7FF);
    chk(msel, 32'h0);
    e = '0;
    e.tx_empty = 3'h2;
    e.rx_loaded = 2'h2;
    i_cisl_can_model.fire(e);
    repeat (2) @(posedge clk_i);
    rd(4'h1, 32'h22);
    chk(irq, 32'h1);
    wb(1'b1, 4'h1, 32'h7FF);
    rd(4'h1, 32'h22);
    wb(1'b1, 4'h1, 32'h7DD);
    rd(4'h1, 32'h0);
    chk(irq, 32'h0);
    ce <= 1'b0;
    i_cisl_can_model.fire(e);
    ce <= 1'b1;
    rd(4'h1, 32'h0);
  endtask : t_legacy
  task automatic t_shared();
    wb(1'b1, 4'h0, 32'h1);
    wb(1'b1, 4'h3, 32'h37);
    e = '0;
    e.tx_req = 3'h5;
    e.rx_full = 2'h2;
    i_cisl_can_model.hold(e);
    @(posedge clk_i);
    e.tx_done = 3'h4;
    e.tx_empty = 3'h7;
    e.rx_loaded = 2'h1;
    i_cisl_can_model.fire(e);
    repeat (2) @(posedge clk_i);
    rd(4'h1, 32'h48);
    rd(4'h6, 32'h0001_0025);
    wb(1'b1, 4'h1, 32'h0);
    wb(1'b1, 4'h3, 32'h0);
    i_cisl_can_model.fire(e);
    repeat (3) @(posedge clk_i);
    chk(irq, 32'h0);
  endtask : t_shared
  task automatic t_fifo();
    wb(1'b1, 4'h0, 32'h6);
    wb(1'b1, 4'h3, 32'h37);
    e = '0;
    e.fifo_count = 4'h4;
    e.fifo_ptr = 3'h5;
    i_cisl_can_model.hold(e);
    @(posedge clk_i);
    e.rx_loaded = 2'h1;
    i_cisl_can_model.fire(e);
    repeat (2) @(posedge clk_i);
    rd(4'h1, 32'hC0);
    rd(4'h6, 32'h0001_0500);
    wb(1'b1, 4'h1, 32'h0);
    rd(4'h1, 32'h80);
    wb(1'b1, 4'h0, 32'h2);
    e.rx_loaded = 2'h0;
    e.fifo_count = 4'h7;
    i_cisl_can_model.hold(e);
    wb(1'b1, 4'h1, 32'h0);
    rd(4'h1, 32'h0);
    e.fifo_count = 4'h8;
    i_cisl_can_model.hold(e);
    repeat (2) @(posedge clk_i);
    rd(4'h1, 32'h80);
  endtask : t_fifo
  task automatic t_errors();
    e = '0;
    i_cisl_can_model.hold(e);
    wb(1'b1, 4'h0, 32'h0);
    wb(1'b1, 4'h1, 32'h0);
    e.rx_errcnt = 8'h5F;
    e.tx_errcnt = 9'h07F;
    i_cisl_can_model.hold(e);
    repeat (2) @(posedge clk_i);
    rd(4'h4, 32'h08);
    sleep_i <= 1'b1;
    e.msg_error = 1'b1;
    e.bus_activity = 1'b1;
    e.rx_nobuf = 2'h1;
    i_cisl_can_model.fire(e);
    @(posedge clk_i);
    chk(wake, 32'h1);
    sleep_i <= 1'b0;
    e = '0;
    e.rx_errcnt = 8'h60;
    e.tx_errcnt = 9'h080;
    i_cisl_can_model.hold(e);
    repeat (2) @(posedge clk_i);
    rd(4'h4, 32'h2D);
    chk(est, cisl_pkg::ST_PASSIVE);
    e.rx_errcnt = 8'h80;
    e.tx_errcnt = 9'h100;
    i_cisl_can_model.hold(e);
    repeat (2) @(posedge clk_i);
    rd(4'h4, 32'h7D);
    rd(4'h6, 32'h0004_0000);
    chk(est, cisl_pkg::ST_BUSOFF);
    rd(4'h1, 32'h700);
    chk(irq, 32'h1);
    wb(1'b1, 4'h4, 32'h0);
    rd(4'h4, 32'h7C);
  endtask : t_errors
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      bad_count++;
      complete_run();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_legacy();
    t_shared();
    t_fifo();
    t_errors();
    complete_run();
  end
endmodule : tb_top
